// ---- cip_pkg.sv ----
// Overview of operation
// R1 - CPU level is core-control bit 3 above status bits 7 to 5
// R2 - Low codes 0..6 give levels 0..6, or 8..14 with top bit set
// R3 - Low code 7 gives level 7 or 15; user interrupts blocked
// R4 - Top bit set blocks every user interrupt
// R5 - Top bit means level above 7; software clears only; resets to 0
// R6 - Nesting disable set makes the low level field read-only
// R7 - Flag status 3 bit 9 sets on pwm special event request
// R8 - Flag status 4 bit 1 sets on uart error request
// R9 - Enable 1 bit 13 gates external irq 2, bit 4 external irq 1
// R10 - Enable 1 bit 3 change notify, bit 2 comparator; reset disabled
// R11 - Enable 1 bit 1 i2c master, bit 0 i2c slave; 1 enables
// R12 - Priority 3 holds adc done at 6:4, uart tx at 2:0
// R13 - Request shown when flag and enable set and priority beats CPU level
// R14 - Unimplemented bits read 0 and ignore writes
package cip_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CORE = 8'h04;
    localparam logic [7:0] ADDR_IRQCTL = 8'h08;
    localparam logic [7:0] ADDR_FLAG3 = 8'h0C;
    localparam logic [7:0] ADDR_FLAG4 = 8'h10;
    localparam logic [7:0] ADDR_ENABLE1 = 8'h14;
    localparam logic [7:0] ADDR_PRIO3 = 8'h18;
    localparam logic [7:0] ADDR_PEND = 8'h1C;
    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int LVL_LSB = 5;
    localparam int LVL_MSB = 7;
    localparam int TOP_BIT = 3;
    localparam int NEST_BIT = 15;
    localparam int PWM_EV_BIT = 9;
    localparam int UART_ERR_BIT = 1;
    localparam int EXT2_BIT = 13;
    localparam int EXT1_BIT = 4;
    localparam int CN_BIT = 3;
    localparam int CMP_BIT = 2;
    localparam int I2CM_BIT = 1;
    localparam int I2CS_BIT = 0;
    localparam int ADC_PRI_LSB = 4;
    localparam int UTX_PRI_LSB = 0;
    localparam logic [15:0] ENABLE1_MASK = 16'h201F;
    localparam logic [15:0] PRIO3_MASK = 16'h0077;
    localparam logic [15:0] PRIO3_RESET = 16'h0044;
    localparam logic [2:0] LVL_MAX = 3'h7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cip_pkg

// ---- cip_level_cmp.sv ----
`timescale 1ns/1ps
module cip_level_cmp
    import cip_pkg::*;
(
    input wire logic [2:0] levelLow,
    input wire logic levelTop,
    input wire logic [2:0] srcPrio,
    input wire logic srcFlag,
    input wire logic srcEnable,
    output logic srcRequest
);
    wire logic [3:0] cpuLevel = {levelTop, levelLow}; // R1 R2 R3
    wire logic [3:0] srcLevel = {1'b0, srcPrio};
    // Priority 0 never beats level 0, so code 000 disables the source
    assign srcRequest = srcFlag && srcEnable && !levelTop &&
                        (srcLevel > cpuLevel); // R13 R4 R3 R12
endmodule : cip_level_cmp

// ---- cip_regs.sv ----
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module cip_regs
    import cip_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pwmEventReq,
    input wire logic uartErrorReq,
    input wire logic ext2Flag,
    input wire logic ext1Flag,
    input wire logic changeNotifyFlag,
    input wire logic comparatorFlag,
    input wire logic i2cMasterFlag,
    input wire logic i2cSlaveFlag,
    input wire logic adcDoneFlag,
    input wire logic uartTxFlag,
    input wire logic cpuLevelLoad,
    input wire logic [3:0] cpuLevelIn,
    output logic [3:0] cpuLevel,
    output logic [7:0] irqRequest
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rstSync1_ff;
    logic rstSync2_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    wire logic rstLocal_n = rstSync2_ff;

    // ------------------------------------------------------------
    // Bus slave: latch address and data in any order
    // ------------------------------------------------------------
    logic awHeld_ff;
    logic wHeld_ff;
    logic [7:0] awAddr_ff;
    logic [15:0] wData_ff;
    logic [1:0] wStrb_ff;
    logic bValid_ff;
    logic [1:0] bResp_ff;
    logic rValid_ff;
    logic [31:0] rData_ff;
    logic [1:0] rResp_ff;

    assign s_axi_awready = !awHeld_ff && !bValid_ff;
    assign s_axi_wready = !wHeld_ff && !bValid_ff;
    assign s_axi_arready = !rValid_ff;
    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;
    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;

    wire logic awTake = s_axi_awvalid && s_axi_awready;
    wire logic wTake = s_axi_wvalid && s_axi_wready;
    wire logic arTake = s_axi_arvalid && s_axi_arready;
    wire logic doWrite = awHeld_ff && wHeld_ff;

    function automatic logic known(input logic [7:0] a);
        known = (a == ADDR_STATUS) || (a == ADDR_CORE) ||
                (a == ADDR_IRQCTL) || (a == ADDR_FLAG3) ||
                (a == ADDR_FLAG4) || (a == ADDR_ENABLE1) ||
                (a == ADDR_PRIO3) || (a == ADDR_PEND);
    endfunction : known

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] dat,
                                          input logic [1:0] stb,
                                          input logic [15:0] msk);
        logic [15:0] lane;
        lane = {{8{stb[1]}}, {8{stb[0]}}} & msk;
        merge = (old & ~lane) | (dat & lane); // R14
    endfunction : merge

    always_ff @(posedge clock or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff <= 16'h0000;
            wStrb_ff <= 2'h0;
            bValid_ff <= 1'b0;
            bResp_ff <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (wTake) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata[15:0];
                wStrb_ff <= s_axi_wstrb[1:0];
            end
            if (doWrite) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                bValid_ff <= 1'b1;
                bResp_ff <= known(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid_ff && s_axi_bready) begin
                bValid_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0] lvlLow_ff;
    logic lvlTop_ff;
    logic nestDis_ff;
    logic pwmEvent_ff;
    logic uartErr_ff;
    logic [15:0] enable1_ff;
    logic [15:0] prio3_ff;

    wire logic wrStatus = doWrite && (awAddr_ff == ADDR_STATUS);
    wire logic wrCore = doWrite && (awAddr_ff == ADDR_CORE);
    wire logic wrIrqCtl = doWrite && (awAddr_ff == ADDR_IRQCTL);
    wire logic wrFlag3 = doWrite && (awAddr_ff == ADDR_FLAG3);
    wire logic wrFlag4 = doWrite && (awAddr_ff == ADDR_FLAG4);
    wire logic wrEnable1 = doWrite && (awAddr_ff == ADDR_ENABLE1);
    wire logic wrPrio3 = doWrite && (awAddr_ff == ADDR_PRIO3);

    // Low lane holds the level field; nesting disable locks it
    wire logic lvlWrite = wrStatus && wStrb_ff[0] && !nestDis_ff; // R6
    // Top bit is clear-only from software; core may load any level
    wire logic topClear = wrCore && wStrb_ff[0] &&
                          !wData_ff[TOP_BIT]; // R5

    wire logic [2:0] nxt_lvlLow = cpuLevelLoad ? cpuLevelIn[2:0] :
                     lvlWrite ? wData_ff[LVL_MSB:LVL_LSB] : lvlLow_ff;
    wire logic nxt_lvlTop = cpuLevelLoad ? cpuLevelIn[3] :
                     topClear ? 1'b0 : lvlTop_ff; // R5
    // Hardware set wins over a software clear in the same cycle
    wire logic nxt_pwmEvent = pwmEventReq ||
        ((wrFlag3 && wStrb_ff[1]) ? wData_ff[PWM_EV_BIT] :
         pwmEvent_ff); // R7
    wire logic nxt_uartErr = uartErrorReq ||
        ((wrFlag4 && wStrb_ff[0]) ? wData_ff[UART_ERR_BIT] :
         uartErr_ff); // R8

    always_ff @(posedge clock or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            lvlLow_ff <= 3'h0;
            lvlTop_ff <= 1'b0; // R5
            nestDis_ff <= 1'b0;
            pwmEvent_ff <= 1'b0;
            uartErr_ff <= 1'b0;
            enable1_ff <= 16'h0000; // R10
            prio3_ff <= PRIO3_RESET;
        end else begin
            lvlLow_ff <= nxt_lvlLow; // R1
            lvlTop_ff <= nxt_lvlTop;
            if (wrIrqCtl && wStrb_ff[1]) begin
                nestDis_ff <= wData_ff[NEST_BIT];
            end
            pwmEvent_ff <= nxt_pwmEvent;
            uartErr_ff <= nxt_uartErr;
            if (wrEnable1) begin
                enable1_ff <= merge(enable1_ff, wData_ff, wStrb_ff,
                                    ENABLE1_MASK); // R9 R10 R11
            end
            if (wrPrio3) begin
                prio3_ff <= merge(prio3_ff, wData_ff, wStrb_ff,
                                  PRIO3_MASK); // R12
            end
        end
    end

    assign cpuLevel = {lvlTop_ff, lvlLow_ff}; // R1 R2

    // ------------------------------------------------------------
    // Request qualification
    // ------------------------------------------------------------
    wire logic [2:0] adcPrio = prio3_ff[ADC_PRI_LSB +: 3]; // R12
    wire logic [2:0] utxPrio = prio3_ff[UTX_PRI_LSB +: 3]; // R12
    // Sources without a priority field here run at the top user level
    wire logic [7:0] srcFlags = {uartTxFlag, adcDoneFlag, ext2Flag,
        ext1Flag, changeNotifyFlag, comparatorFlag, i2cMasterFlag,
        i2cSlaveFlag};
    wire logic [7:0] srcEn = {1'b1, 1'b1, enable1_ff[EXT2_BIT],
        enable1_ff[EXT1_BIT], enable1_ff[CN_BIT], enable1_ff[CMP_BIT],
        enable1_ff[I2CM_BIT], enable1_ff[I2CS_BIT]}; // R9 R10 R11
    wire logic [23:0] srcPrio = {utxPrio, adcPrio, {6{LVL_MAX}}};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_src
            cip_level_cmp u_cmp (
                .levelLow(lvlLow_ff),
                .levelTop(lvlTop_ff),
                .srcPrio(srcPrio[gi*3 +: 3]),
                .srcFlag(srcFlags[gi]),
                .srcEnable(srcEn[gi]),
                .srcRequest(irqRequest[gi])
            ); // R13 R4
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic [7:0] rdAddr = {s_axi_araddr[7:2], 2'b00};
    logic [15:0] rdWord;
    always_comb begin
        rdWord = 16'h0000; // R14
        unique case (rdAddr)
            ADDR_STATUS: rdWord[LVL_MSB:LVL_LSB] = lvlLow_ff;
            ADDR_CORE: rdWord[TOP_BIT] = lvlTop_ff; // R5
            ADDR_IRQCTL: rdWord[NEST_BIT] = nestDis_ff;
            ADDR_FLAG3: rdWord[PWM_EV_BIT] = pwmEvent_ff;
            ADDR_FLAG4: rdWord[UART_ERR_BIT] = uartErr_ff;
            ADDR_ENABLE1: rdWord = enable1_ff;
            ADDR_PRIO3: rdWord = prio3_ff;
            ADDR_PEND: rdWord = {8'h00, irqRequest};
            default: rdWord = 16'h0000;
        endcase
    end

    always_ff @(posedge clock or negedge rstLocal_n) begin
        if (!rstLocal_n) begin
            rValid_ff <= 1'b0;
            rData_ff <= 32'h0000_0000;
            rResp_ff <= RESP_OKAY;
        end else if (arTake) begin
            rValid_ff <= 1'b1;
            rData_ff <= {16'h0000, rdWord};
            rResp_ff <= known(rdAddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rValid_ff && s_axi_rready) begin
            rValid_ff <= 1'b0;
        end
    end
endmodule : cip_regs

// ---- cip_regs_chk.sv ----
`timescale 1ns/1ps
module cip_regs_chk
    import cip_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic cpuLevelLoad,
    input wire logic [3:0] cpuLevelIn,
    input wire logic [3:0] cpuLevel,
    input wire logic [7:0] irqRequest
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer:
        assert property (s_wr_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer:
        assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    a_aw_refused:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_ar_refused:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
    a_level_load:
        assert property (cpuLevelLoad |=> cpuLevel == $past(cpuLevelIn))
        else $error("level load lost");
    a_top_blocks:
        assert property (cpuLevel[3] |-> irqRequest == 8'h00)
        else $error("request while top bit set");
    a_full_blocks:
        assert property (cpuLevel[2:0] == 3'h7 |-> irqRequest == 8'h00)
        else $error("request at level seven");
    a_unmapped_rd:
        assert property ((s_axi_arvalid && s_axi_arready
            && s_axi_araddr[7:2] > ADDR_PEND[7:2])
            |=> s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
endmodule : cip_regs_chk
bind cip_regs cip_regs_chk u_chk (
    .clock(clock), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rresp(s_axi_rresp), .cpuLevelLoad(cpuLevelLoad),
    .cpuLevelIn(cpuLevelIn), .cpuLevel(cpuLevel), .irqRequest(irqRequest)
);

// ---- cip_core_model.sv ----
`timescale 1ns/1ps
module cip_core_model (
    input wire logic clock,
    input wire logic [1:0] evtCmd,
    input wire logic [7:0] srcCmd,
    input wire logic lvlCmd,
    input wire logic [3:0] lvlVal,
    output logic pwmEventReq,
    output logic uartErrorReq,
    output logic [7:0] srcFlags,
    output logic cpuLevelLoad,
    output logic [3:0] cpuLevelIn
);
    initial begin
        {pwmEventReq, uartErrorReq, srcFlags, cpuLevelLoad} = '0;
        cpuLevelIn = 4'h0;
    end
    // Level bus toggles when not loaded so a stale value never helps
    always @(posedge clock) begin
        pwmEventReq <= evtCmd[0];
        uartErrorReq <= evtCmd[1];
        srcFlags <= srcCmd;
        cpuLevelLoad <= lvlCmd;
        cpuLevelIn <= lvlCmd ? lvlVal : ~cpuLevelIn;
    end
endmodule : cip_core_model

// ---- tb_cip_regs.sv ----
`timescale 1ns/1ps
module tb_cip_regs
    import cip_pkg::*;
;
    logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr, src, flags, irqRequest, eIrq;
    logic [31:0] wdata, rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, lvlGo;
    logic pwmReq, uartReq, lvlLoad;
    logic [1:0] bresp, rresp, rs, evt;
    logic [3:0] lvl, lvlIn, cpuLevel, l, strb;
    logic [5:0] e, p;
    int fails, total_checks;
    cip_regs u_dut (.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwmEventReq(pwmReq), .uartErrorReq(uartReq),
        .ext2Flag(flags[5]), .ext1Flag(flags[4]),
        .changeNotifyFlag(flags[3]), .comparatorFlag(flags[2]),
        .i2cMasterFlag(flags[1]), .i2cSlaveFlag(flags[0]),
        .adcDoneFlag(flags[6]), .uartTxFlag(flags[7]),
        .cpuLevelLoad(lvlLoad), .cpuLevelIn(lvlIn), .cpuLevel(cpuLevel),
        .irqRequest(irqRequest));
    cip_core_model u_model (.clock(clock), .evtCmd(evt), .srcCmd(src),
        .lvlCmd(lvlGo), .lvlVal(lvl), .pwmEventReq(pwmReq),
        .uartErrorReq(uartReq), .srcFlags(flags), .cpuLevelLoad(lvlLoad),
        .cpuLevelIn(lvlIn));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] x, y);
        total_checks++;
        if (y !== x) begin
            fails++;
            $display("Error %s expected %h seen %h", n, x, y);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        rs = bresp;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clock);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask : rdr
    task automatic load(input logic [3:0] v);
        @(posedge clock);
        {lvlGo, lvl} <= {1'b1, v};
        @(posedge clock);
        lvlGo <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : load
    function automatic logic [7:0] expIrq(logic [3:0] v, logic [7:0] f);
        logic [2:0] pri;
        expIrq = 8'h00;
        for (int i = 0; i < 8; i++) begin
            pri = (i == 6) ? p[5:3] : (i == 7) ? p[2:0] : 3'h7;
            expIrq[i] = f[i] & (i > 5 || e[i % 6]) & (pri > v[2:0]) & ~v[3];
        end
    endfunction : expIrq
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    // Whole run is well under 1,000 cycles; allow 20,000 (200us)
    initial begin
        #200us;
        fails++;
        summarize();
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, lvlGo} = '0;
        {awaddr, araddr, wdata, src, evt, lvl} = '0;
        strb = 4'hF;
        void'($urandom(16));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            rdr(8'(i * 4));
            chk("reset", (i == 6) ? 32'h0000_0044 : 32'h0000_0000, rd);
        end
        wr(ADDR_ENABLE1, 32'hFFFF_FFFF);
        rdr(ADDR_ENABLE1);
        chk("enable1", 32'h0000_201F, rd);
        wr(ADDR_PRIO3, 32'hFFFF_FFFF);
        rdr(ADDR_PRIO3);
        chk("prio3", 32'h0000_0077, rd);
        chk("rresp ok", {30'h0, RESP_OKAY}, {30'h0, rs});
        // High lane only: the low byte of enable 1 must survive
        strb <= 4'h2;
        wr(ADDR_ENABLE1, 32'h0000_0000);
        strb <= 4'hF;
        rdr(ADDR_ENABLE1);
        chk("strobe", 32'h0000_001F, rd);
        wr(8'h20, 32'hFFFF_FFFF);
        chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        rdr(8'h20);
        chk("rdata", 32'h0000_0000, rd);
        chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        $display("map test done");
        @(posedge clock);
        evt <= 2'b11;
        @(posedge clock);
        evt <= 2'b00;
        rdr(ADDR_FLAG3);
        chk("flag3", 32'h0000_0200, rd);
        rdr(ADDR_FLAG4);
        chk("flag4", 32'h0000_0002, rd);
        wr(ADDR_FLAG3, 32'h0000_0000);
        wr(ADDR_FLAG4, 32'h0000_0000);
        rdr(ADDR_FLAG3);
        chk("flag3 clear", 32'h0000_0000, rd);
        rdr(ADDR_FLAG4);
        chk("flag4 clear", 32'h0000_0000, rd);
        $display("flag test done");
        load(4'hA);
        rdr(ADDR_STATUS);
        chk("status", 32'h0000_0040, rd);
        rdr(ADDR_CORE);
        chk("core", 32'h0000_0008, rd);
        wr(ADDR_CORE, 32'h0000_0000);
        wr(ADDR_CORE, 32'h0000_0008);
        chk("top clear", 32'h0000_0002, {28'h0, cpuLevel});
        wr(ADDR_IRQCTL, 32'h0000_8000);
        wr(ADDR_STATUS, 32'h0000_0020);
        chk("nest", 32'h0000_0002, {28'h0, cpuLevel});
        wr(ADDR_IRQCTL, 32'h0000_0000);
        wr(ADDR_STATUS, 32'h0000_00E0);
        chk("low field", 32'h0000_0007, {28'h0, cpuLevel});
        $display("level test done");
        for (int i = 0; i < 24; i++) begin
            l = (i == 0) ? 4'h7 : (i == 1) ? 4'h0 :
                (i == 2) ? 4'h8 : 4'($urandom);
            e = 6'($urandom);
            p = (i == 1) ? 6'h00 : 6'($urandom);
            wr(ADDR_ENABLE1, {18'h0, e[5], 8'h00, e[4:0]});
            wr(ADDR_PRIO3, {25'h0, p[5:3], 1'b0, p[2:0]});
            @(posedge clock);
            src <= 8'($urandom);
            load(l);
            eIrq = expIrq(l, src);
            chk("irq", {24'h0, eIrq}, {24'h0, irqRequest});
            rdr(ADDR_PEND);
            chk("pending", {24'h0, eIrq}, rd);
        end
        $display("request test done");
        // Mid-run reset must bring priority 3, enable 1 and the CPU level back to their reset values
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rdr(ADDR_PRIO3);
        chk("reset prio3", 32'h0000_0044, rd);
        rdr(ADDR_ENABLE1);
        chk("reset enable1", 32'h0000_0000, rd);
        chk("reset level", 32'h0000_0000, {28'h0, cpuLevel});
        $display("reset test done");
        summarize();
    end
endmodule : tb_cip_regs
